// *** verilog/pcr_top.sv ***
// Pulse-count command decoder and protection control
`timescale 1ns/10ps
module pcr_top #(
  parameter int unsigned IDLE_CYCLES  = pcr_pkg::IDLE_CYC,
  parameter int unsigned DISCH_CYCLES = pcr_pkg::DISCH_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          pulse_command_line,
  input  wire logic          analog_rail_enable,
  input  wire logic          uvlo_low,
  input  wire logic          over_current,
  input  wire logic          short_detect,
  input  wire logic          over_temp,
  input  wire logic          temp_cooled,
  output logic               pos_rail_en,
  output logic               neg_rail_en,
  output logic               neg_discharge,
  output logic               neg_hiz,
  output logic [5:0]         pos_code,
  output logic [5:0]         neg_code,
  output logic [5:0]         pump_code,
  output logic [5:0]         bb_code,
  output logic               switch_off,
  output logic               short_circuit_latch,
  output logic               bias_stop,
  output logic               device_off,
  output logic               line_active
);
  import pcr_pkg::*;

  logic [2:0] s1_r, s2_r;
  logic       pl_r, ae_r, uv_r, oc_r, sc_r, ot_r, tc_r;
  logic       pl_d_r;
  logic [7:0] cnt_r;
  logic [31:0] idle_r;
  logic       burst_r, done_r;
  logic [7:0] cmd_r;
  logic       run_r;
  pcr_neg_t   neg_st_r;
  logic [31:0] dis_r;
  logic [5:0] pos_r, neg_r, mx;
  logic       shut;

  // Three-flop synchronisers for line, enable and UVLO, single flop for the fault inputs; first stage read only by second
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      s1_r <= 3'h0; s2_r <= 3'h0;
      uv_r <= 1'b0; oc_r <= 1'b0; sc_r <= 1'b0; ot_r <= 1'b0; tc_r <= 1'b0;
      pl_r <= 1'b0; ae_r <= 1'b0;
    end
    else
    begin
      s1_r <= {pulse_command_line, analog_rail_enable, uvlo_low};
      s2_r <= s1_r;
      pl_r <= s2_r[2];
      ae_r <= s2_r[1];
      uv_r <= s2_r[0];
      oc_r <= over_current;
      sc_r <= short_detect;
      ot_r <= over_temp;
      tc_r <= temp_cooled;
    end

  assign shut = uv_r | short_circuit_latch;

  // Pulse counting and idle detection
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pl_d_r <= 1'b0; cnt_r <= 8'h00; idle_r <= '0;
      burst_r <= 1'b0; done_r <= 1'b0; cmd_r <= 8'h00; run_r <= 1'b0;
    end
    else
    begin
      pl_d_r <= pl_r;
      done_r <= 1'b0;
      run_r  <= !shut;
      if (shut || (!run_r))
      begin
        cnt_r <= 8'h00;
        burst_r <= 1'b0;
        idle_r <= '0;
      end
      else if (pl_r && !pl_d_r)
      begin
        if (cnt_r != 8'hFF)
          cnt_r <= cnt_r + 8'h01;
        burst_r <= 1'b1;
        idle_r <= '0;
      end
      else if (!pl_r)
      begin
        if (idle_r < IDLE_CYCLES)
          idle_r <= idle_r + 32'h1;
        else if (burst_r)
        begin
          done_r  <= 1'b1;
          cmd_r   <= cnt_r;
          cnt_r   <= 8'h00;
          burst_r <= 1'b0;
        end
      end
      else
        idle_r <= '0;
    end

  // Line on seen at once on a high, off only after 300us low
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      line_active <= 1'b0;
    else if (pl_r)
      line_active <= 1'b1;
    else if (idle_r >= IDLE_CYCLES)
      line_active <= 1'b0;

  // Command decode on burst end; unknown counts fall through
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pos_r <= POS_DEF; neg_r <= NEG_DEF; pos_rail_en <= 1'b0;
    end
    else if (shut)
    begin
      pos_rail_en <= 1'b0;
    end
    else if (done_r)
    begin
      if (cmd_r == CMD_SOFT_RST)
      begin
        pos_r <= POS_DEF; neg_r <= NEG_DEF; pos_rail_en <= 1'b0;
      end
      else if (cmd_r == CMD_POS_ON)
        pos_rail_en <= 1'b1;
      else if (cmd_r == CMD_POS_OFF)
        pos_rail_en <= 1'b0;
      else if (cmd_r >= POS_LO && cmd_r <= POS_HI)
        pos_r <= 6'(POS_BASE + 6'(cmd_r - POS_LO));
      else if (cmd_r >= NEG_LO && cmd_r <= NEG_HI)
        neg_r <= 6'(NEG_BASE - 6'(cmd_r - NEG_LO));
    end

  // Negative rail and pump state
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      neg_st_r <= PCR_NEG_OFF; dis_r <= '0;
    end
    else if (shut || (done_r && cmd_r == CMD_SOFT_RST))
    begin
      neg_st_r <= PCR_NEG_OFF; dis_r <= '0;
    end
    else if (done_r && cmd_r == CMD_NEG_ON)
      neg_st_r <= PCR_NEG_ON;
    else if (done_r && cmd_r == CMD_NEG_OFF)
      neg_st_r <= PCR_NEG_OFF;
    else if (done_r && cmd_r == CMD_NEG_DISCH)
    begin
      neg_st_r <= PCR_NEG_DISCH; dis_r <= '0;
    end
    else
      case (neg_st_r)
        PCR_NEG_DISCH:
          if (dis_r >= DISCH_CYCLES - 1)
            neg_st_r <= PCR_NEG_HIZ;
          else
            dis_r <= dis_r + 32'h1;
        PCR_NEG_OFF, PCR_NEG_ON, PCR_NEG_HIZ: ;
        default: neg_st_r <= PCR_NEG_OFF;
      endcase

  always_comb
  begin
    mx = FIXED_RAIL;
    if (pos_r > mx) mx = pos_r;
    if (neg_r > mx) mx = neg_r;
  end

  // Registered outputs
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      neg_rail_en <= 1'b0; neg_discharge <= 1'b0; neg_hiz <= 1'b0;
      pos_code <= POS_DEF; neg_code <= NEG_DEF;
      // Targets follow the default codes so the margin checks hold from the first edge
      pump_code <= 6'(NEG_DEF + PUMP_MARGIN);
      bb_code <= 6'(FIXED_RAIL + BB_MARGIN);
      device_off <= 1'b1;
    end
    else
    begin
      neg_rail_en   <= (neg_st_r == PCR_NEG_ON);
      neg_discharge <= (neg_st_r == PCR_NEG_DISCH);
      neg_hiz       <= (neg_st_r == PCR_NEG_HIZ);
      pos_code      <= pos_r;
      neg_code      <= neg_r;
      pump_code     <= 6'(neg_r + PUMP_MARGIN);
      bb_code       <= 6'(mx + BB_MARGIN);
      device_off    <= (!ae_r && !line_active) || shut;
    end

  // Protection
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      switch_off <= 1'b0;
    else
      switch_off <= oc_r || shut;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      short_circuit_latch <= 1'b0;
    else if (sc_r)
      short_circuit_latch <= 1'b1;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      bias_stop <= 1'b0;
    else if (ot_r)
      bias_stop <= 1'b1;
    else if (tc_r)
      bias_stop <= 1'b0;

  property p_scp_sticky;
    @(posedge core_clk) disable iff (rst)
      short_circuit_latch |=> short_circuit_latch;
  endproperty
  a_scp_sticky: assert property (p_scp_sticky) else $error("short latch cleared");

  property p_ocp;
    @(posedge core_clk) disable iff (rst)
      over_current |-> ##2 switch_off;
  endproperty
  a_ocp: assert property (p_ocp) else $error("switch not forced off");

  property p_otp;
    @(posedge core_clk) disable iff (rst)
      (over_temp && !temp_cooled) |-> ##2 bias_stop;
  endproperty
  a_otp: assert property (p_otp) else $error("bias not stopped");

  property p_bb;
    @(posedge core_clk) disable iff (rst)
      (bb_code >= 6'(FIXED_RAIL + BB_MARGIN)) && (bb_code >= 6'($past(pos_r) + BB_MARGIN));
  endproperty
  a_bb: assert property (p_bb) else $error("buck-boost target low");

  property p_pump;
    @(posedge core_clk) disable iff (rst)
      pump_code == 6'(neg_code + PUMP_MARGIN);
  endproperty
  a_pump: assert property (p_pump) else $error("pump margin wrong");

  property p_pos_on;
    @(posedge core_clk) disable iff (rst)
      (done_r && cmd_r == CMD_POS_ON && !shut) |=> pos_rail_en;
  endproperty
  a_pos_on: assert property (p_pos_on) else $error("positive rail not on");

  property p_pos_off;
    @(posedge core_clk) disable iff (rst)
      (done_r && cmd_r == CMD_POS_OFF) |=> !pos_rail_en;
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("positive rail not off");

  property p_srst;
    @(posedge core_clk) disable iff (rst)
      (done_r && cmd_r == CMD_SOFT_RST) |=> (pos_r == POS_DEF && neg_r == NEG_DEF);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset incomplete");

  property p_uvlo;
    @(posedge core_clk) disable iff (rst)
      uv_r |=> (device_off && !pos_rail_en);
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout ignored");

  property p_clear;
    @(posedge core_clk) disable iff (rst)
      done_r |-> cnt_r == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");
endmodule : pcr_top

// *** pkg/pcr_pkg.sv ***
// Constants and types for the pulse-count rail controller
package pcr_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned IDLE_US      = 300;
  localparam int unsigned IDLE_CYC     = (IDLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DISCH_US     = 1000;
  localparam int unsigned DISCH_CYC    = (DISCH_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] CMD_POS_ON    = 8'h74;
  localparam logic [7:0] CMD_NEG_ON    = 8'h75;
  localparam logic [7:0] CMD_POS_OFF   = 8'h76;
  localparam logic [7:0] CMD_NEG_OFF   = 8'h77;
  localparam logic [7:0] CMD_NEG_DISCH = 8'h78;
  localparam logic [7:0] CMD_SOFT_RST  = 8'h79;
  localparam logic [7:0] POS_LO        = 8'h0A;
  localparam logic [7:0] POS_HI        = 8'h16;
  localparam logic [7:0] NEG_LO        = 8'h3A;
  localparam logic [7:0] NEG_HI        = 8'h5C;
  // Voltages in units of 0.1V (magnitudes)
  localparam logic [5:0] POS_BASE      = 6'h1C;
  localparam logic [5:0] NEG_BASE      = 6'h28;
  localparam logic [5:0] POS_DEF       = 6'h21;
  localparam logic [5:0] NEG_DEF       = 6'h21;
  localparam logic [5:0] FIXED_RAIL    = 6'h21;
  localparam logic [5:0] PUMP_MARGIN   = 6'h01;
  localparam logic [5:0] BB_MARGIN     = 6'h02;
  typedef enum logic [1:0] {
    PCR_NEG_OFF   = 2'b00,
    PCR_NEG_ON    = 2'b01,
    PCR_NEG_DISCH = 2'b11,
    PCR_NEG_HIZ   = 2'b10
  } pcr_neg_t;
endpackage : pcr_pkg

// *** test/pcr_host.sv ***
// Host model that sends pulse bursts on the command line
`timescale 1ns/10ps
module pcr_host #(
  parameter int unsigned GAP = 30
) (
  input  wire logic core_clk,
  output logic      pulse_command_line
);
  integer seed = 31917;

  // Line idles low, as the pin's pull-down would hold it
  initial pulse_command_line = 1'b0;

  // Phases are scaled with the shortened idle time; a low phase stays well below it
  task automatic send_burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      pulse_command_line = 1'b1;
      repeat (2 + $unsigned($random(seed)) % 5) @(negedge core_clk);
      pulse_command_line = 1'b0;
      repeat (2 + $unsigned($random(seed)) % 5) @(negedge core_clk);
    end
    repeat (GAP) @(negedge core_clk);
  endtask : send_burst
endmodule : pcr_host

// *** test/tb_pcr_top.sv ***
// Self-checking bench for the pulse-count rail controller
`timescale 1ns/10ps
module tb_pcr_top;
  import pcr_pkg::*;
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
  logic core_clk, rst, pulse_command_line, analog_rail_enable, uvlo_low;
  logic over_current, short_detect, over_temp, temp_cooled;
  logic pos_rail_en, neg_rail_en, neg_discharge, neg_hiz, switch_off;
  logic short_circuit_latch, bias_stop, device_off, line_active;
  logic [5:0] pos_code, neg_code, pump_code, bb_code, pexp, nexp;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  integer seed = 31917;
  int odd[6] = '{9, 23, 57, 93, 115, 122};

  pcr_top #(.IDLE_CYCLES(20), .DISCH_CYCLES(40)) pcr_top_i (.core_clk(core_clk), .rst(rst),
    .pulse_command_line(pulse_command_line), .analog_rail_enable(analog_rail_enable),
    .uvlo_low(uvlo_low), .over_current(over_current), .short_detect(short_detect),
    .over_temp(over_temp), .temp_cooled(temp_cooled), .pos_rail_en(pos_rail_en),
    .neg_rail_en(neg_rail_en), .neg_discharge(neg_discharge), .neg_hiz(neg_hiz),
    .pos_code(pos_code), .neg_code(neg_code), .pump_code(pump_code), .bb_code(bb_code),
    .switch_off(switch_off), .short_circuit_latch(short_circuit_latch),
    .bias_stop(bias_stop), .device_off(device_off), .line_active(line_active));
  pcr_host pcr_host_i (.core_clk(core_clk), .pulse_command_line(pulse_command_line));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [5:0] bb_exp(input logic [5:0] p, input logic [5:0] q);
    logic [5:0] m;
    m = FIXED_RAIL;
    if (p > m) m = p;
    if (q > m) m = q;
    return m + BB_MARGIN;
  endfunction : bb_exp

  task automatic cmd(input int k);
    pcr_host_i.send_burst(k);
    repeat (5) @(negedge core_clk);
  endtask : cmd

  task automatic chk_codes();
    `CHK(pos_code, pexp)
    `CHK(neg_code, nexp)
    `CHK(pump_code, nexp + PUMP_MARGIN)
    `CHK(bb_code, bb_exp(pexp, nexp))
  endtask : chk_codes

  task automatic wt(input int c);
    repeat (c) @(negedge core_clk);
  endtask : wt

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {rst, uvlo_low, over_current, short_detect, over_temp, temp_cooled} = 6'h20;
    analog_rail_enable = 1'b1;
    wt(10);
    rst = 1'b0;
    wt(6);
    pexp = POS_DEF;
    nexp = NEG_DEF;
    chk_codes();
    `CHK(device_off, 1'b0)
    `CHK(line_active, 1'b0)
    for (int k = 0; k < 4; k++)
    begin
      cmd(116 + k);
      `CHK(pos_rail_en, 1'(k < 2))
      `CHK(neg_rail_en, 1'(k == 1 || k == 2))
    end
    for (int i = 0; i < 16; i++)
    begin
      n = (i < 4) ? odd[i] : 0;
      case (i)
        0: n = 10;
        1: n = 22;
        2: n = 58;
        3: n = 92;
        default: n = ($random(seed) & 1) ? 10 + $unsigned($random(seed)) % 13
                                         : 58 + $unsigned($random(seed)) % 35;
      endcase
      if (n < 58) pexp = POS_BASE + 6'(n - 10);
      else nexp = NEG_BASE - 6'(n - 58);
      cmd(n);
      chk_codes();
      if (i < 6)
      begin
        cmd(odd[i]);
        chk_codes();
        `CHK(pos_rail_en, 1'b0)
      end
    end
    cmd(117);
    cmd(120);
    `CHK(neg_discharge, 1'b1)
    wt(45);
    `CHK(neg_hiz, 1'b1)
    `CHK(neg_discharge, 1'b0)
    cmd(116);
    cmd(121);
    pexp = POS_DEF;
    nexp = NEG_DEF;
    chk_codes();
    `CHK(pos_rail_en, 1'b0)
    pexp = POS_BASE + 6'h05;
    fork
      cmd(15);
      begin
        wt(8);
        `CHK(line_active, 1'b1)
      end
    join
    `CHK(line_active, 1'b0)
    chk_codes();
    uvlo_low = 1'b1;
    wt(6);
    `CHK(device_off, 1'b1)
    cmd(116);
    uvlo_low = 1'b0;
    wt(30);
    `CHK(pos_rail_en, 1'b0)
    cmd(116);
    `CHK(pos_rail_en, 1'b1)
    over_current = 1'b1;
    wt(3);
    `CHK(switch_off, 1'b1)
    over_current = 1'b0;
    wt(3);
    `CHK(switch_off, 1'b0)
    over_temp = 1'b1;
    wt(3);
    `CHK(bias_stop, 1'b1)
    over_temp = 1'b0;
    wt(3);
    `CHK(bias_stop, 1'b1)
    temp_cooled = 1'b1;
    wt(3);
    `CHK(bias_stop, 1'b0)
    temp_cooled = 1'b0;
    analog_rail_enable = 1'b0;
    wt(6);
    `CHK(device_off, 1'b1)
    analog_rail_enable = 1'b1;
    wt(6);
    `CHK(device_off, 1'b0)
    short_detect = 1'b1;
    wt(3);
    short_detect = 1'b0;
    wt(20);
    `CHK(short_circuit_latch, 1'b1)
    rst = 1'b1;
    wt(2);
    rst = 1'b0;
    wt(3);
    `CHK(short_circuit_latch, 1'b0)
    end_of_test();
  end
endmodule : tb_pcr_top
